// [src/act_adc_timing.sv]
// Conversion timing and output control for a clocked converter.
// Assumes a 10 MHz hclk, AHB-Lite registers, and a sample bus from the analog front end.
// Function
// - Capture sample on each conversion clock rise past the minimum interval.
// - Result changes exactly one latency after start.
// - Valid drops at update, returns after duration.
// - Overlapping starts allowed past minimum interval.
// - Too-early starts not captured; they only set the sticky drop flag.
// - Result width one to thirty-two bits.
// - Offset binary default, two's complement optional.
`timescale 1ns/10ps
module act_adc_timing #(
	parameter int N = 12,
	parameter int SW = 32
) (
	// AHB-Lite slave.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter pins.
	input wire logic conv_clk,
	input wire logic [SW-1:0] sample_in,
	output logic [N-1:0] result_q,
	output logic result_valid_q,
	// Downstream stream of results.
	output logic res_strm_valid_q,
	input wire logic res_strm_ready
);
	localparam int DEPTH = act_pkg::CONV_CYC * 2 + 2;

	////////////////////////////////////////////////////////////////////////////
	// Registers.
	logic signed_q;
	logic signed [31:0] offset_q;
	logic [31:0] range_q;
	logic [15:0] conv_q;
	logic [15:0] minst_q;
	logic [15:0] vlow_q;
	logic dropped_q;
	logic ap_q;
	logic ap_wr_q;
	logic [7:0] ap_addr_q;

	// Address phase is taken when selected, NONSEQ and the bus is ready.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_q <= 1'b0;
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h00;
		end else if (hready) begin
			ap_q <= hsel && (htrans == act_pkg::HTRANS_NONSEQ);
			ap_wr_q <= hwrite;
			ap_addr_q <= haddr[7:0];
		end
	end

	// Zero wait states; response is always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Register writes in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			signed_q <= 1'b0;
			offset_q <= '0;
			range_q <= act_pkg::RANGE_RST;
			conv_q <= 16'(act_pkg::CONV_CYC);
			minst_q <= 16'(act_pkg::MIN_CYC);
			vlow_q <= 16'(act_pkg::VLOW_CYC);
		end else if (ap_q && ap_wr_q) begin
			case (ap_addr_q)
				act_pkg::REG_CTRL: signed_q <= hwdata[act_pkg::CTRL_SIGNED_BIT];
				act_pkg::REG_OFFSET: offset_q <= hwdata;
				act_pkg::REG_RANGE: range_q <= hwdata;
				act_pkg::REG_CONV: conv_q <= hwdata[15:0];
				act_pkg::REG_MINSTART: minst_q <= hwdata[15:0];
				act_pkg::REG_VLOW: vlow_q <= hwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Read data, combinational on the registered address phase.
	always_comb begin
		hrdata = 32'h0000_0000;
		if (ap_q && !ap_wr_q) begin
			case (ap_addr_q)
				act_pkg::REG_CTRL: hrdata = {31'h0, signed_q};
				act_pkg::REG_OFFSET: hrdata = offset_q;
				act_pkg::REG_RANGE: hrdata = range_q;
				act_pkg::REG_CONV: hrdata = {16'h0, conv_q};
				act_pkg::REG_MINSTART: hrdata = {16'h0, minst_q};
				act_pkg::REG_VLOW: hrdata = {16'h0, vlow_q};
				act_pkg::REG_STATUS: hrdata = {30'h0, dropped_q, result_valid_q};
				act_pkg::REG_RESULT: hrdata = 32'(result_q);
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion clock synchroniser and edge detect.
	logic [2:0] cclk_q;
	logic start;
	logic [15:0] since_q;
	logic accept;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cclk_q <= 3'h0;
		end else begin
			cclk_q <= {cclk_q[1:0], conv_clk};
		end
	end
	assign start = cclk_q[1] && !cclk_q[2];

	// Spacing counter since the last accepted start, saturating.
	assign accept = start && (since_q >= minst_q);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_q <= 16'hFFFF;
		end else if (accept) begin
			since_q <= act_pkg::ONE16;
		end else if (since_q != 16'hFFFF) begin
			since_q <= since_q + act_pkg::ONE16;
		end
	end

	// Dropped-start sticky flag, cleared by reading status; a new drop wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dropped_q <= 1'b0;
		end else if (start && !accept) begin
			dropped_q <= 1'b1;
		end else if (ap_q && !ap_wr_q && ap_addr_q == act_pkg::REG_STATUS) begin
			dropped_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample to code mapping.
	function automatic logic [N-1:0] to_code(input logic [SW-1:0] s,
		input logic signed [31:0] off, input logic [31:0] rng, input logic sgn);
		logic signed [63:0] v;
		logic signed [63:0] maxc;
		logic [N-1:0] c;
		v = 64'($signed(s)) - 64'(off);
		v = (v * (64'sd1 <<< N)) / $signed({32'h0, (rng == 0) ? 32'h1 : rng});
		v = v + (64'sd1 <<< (N - 1));
		maxc = (64'sd1 <<< N) - 64'sd1;
		if (v < 0) v = 0;
		if (v > maxc) v = maxc;
		c = v[N-1:0];
		if (sgn) c[N-1] = ~c[N-1];
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pending conversions: capture at start, deliver after latency.
	logic [N-1:0] pend_code_q [DEPTH];
	logic [15:0] pend_cnt_q [DEPTH];
	logic [DEPTH-1:0] pend_v_q;
	logic [$clog2(DEPTH)-1:0] wr_q;
	logic [DEPTH-1:0] due;
	logic [N-1:0] due_code;
	logic any_due;

	always_comb begin
		due_code = '0;
		any_due = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (pend_v_q[i] && pend_cnt_q[i] == act_pkg::ONE16) begin
				due_code = pend_code_q[i];
				any_due = 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_slot
			assign due[g] = pend_v_q[g] && pend_cnt_q[g] == act_pkg::ONE16;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pend_v_q[g] <= 1'b0;
					pend_cnt_q[g] <= 16'h0;
					pend_code_q[g] <= '0;
				end else if (accept && wr_q == g) begin
					pend_v_q[g] <= 1'b1;
					pend_cnt_q[g] <= conv_q;
					pend_code_q[g] <= to_code(sample_in, offset_q, range_q, signed_q);
				end else if (due[g]) begin
					pend_v_q[g] <= 1'b0;
				end else if (pend_v_q[g]) begin
					pend_cnt_q[g] <= pend_cnt_q[g] - act_pkg::ONE16;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= '0;
		end else if (accept) begin
			wr_q <= (wr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result update and valid-low timing.
	logic [15:0] vcnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_q <= '0;
			result_valid_q <= 1'b1;
			vcnt_q <= 16'h0;
		end else if (any_due) begin
			result_q <= due_code;
			result_valid_q <= 1'b0;
			vcnt_q <= vlow_q;
		end else if (vcnt_q > act_pkg::ONE16) begin
			vcnt_q <= vcnt_q - act_pkg::ONE16;
		end else begin
			vcnt_q <= 16'h0;
			result_valid_q <= 1'b1;
		end
	end

	// Results also fill the two-entry buffer; only its valid leaves the block, its data output is left open.
	logic bvalid;
	logic bin_ready;
	act_buf2 #(.W(N)) u_buf (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(any_due),
		.in_ready(bin_ready),
		.in_data(due_code),
		.out_valid(bvalid),
		.out_ready(res_strm_ready),
		.out_data()
	);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_strm_valid_q <= 1'b0;
		end else begin
			res_strm_valid_q <= bvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_early_drop;
		@(posedge hclk) disable iff (!hresetn)
		(start && since_q < minst_q) |=> $stable(wr_q) && dropped_q;
	endproperty
	a_early_drop: assert property (p_early_drop) else $error("early start accepted");

	property p_valid_low;
		@(posedge hclk) disable iff (!hresetn)
		any_due && vlow_q == 16'h1 |=> !result_valid_q ##1 (result_valid_q || any_due);
	endproperty
	a_valid_low: assert property (p_valid_low) else $error("valid low length wrong");

	property p_latency;
		@(posedge hclk) disable iff (!hresetn)
		accept && conv_q == 16'(act_pkg::CONV_CYC) |-> ##10 any_due;
	endproperty
	a_latency: assert property (p_latency) else $error("result not due at latency");

	property p_update;
		@(posedge hclk) disable iff (!hresetn)
		any_due |=> result_q == $past(due_code);
	endproperty
	a_update: assert property (p_update) else $error("result not updated");

	property p_capture;
		@(posedge hclk) disable iff (!hresetn)
		accept |=> pend_v_q[$past(wr_q)];
	endproperty
	a_capture: assert property (p_capture) else $error("start not captured");

	property p_accept;
		@(posedge hclk) disable iff (!hresetn)
		(start && since_q >= minst_q) |=> pend_cnt_q[$past(wr_q)] == $past(conv_q);
	endproperty
	a_accept: assert property (p_accept) else $error("valid start refused");

	property p_stream;
		@(posedge hclk) disable iff (!hresetn)
		any_due |-> bin_ready;
	endproperty
	a_stream: assert property (p_stream) else $error("result buffer overflow");
endmodule // act_adc_timing

// [common/act_pkg.sv]
// Constants shared by the conversion timing block.
// Assumes a single 10 MHz clock and an AHB-Lite register bus with 32-bit data.
package act_pkg;
	// Clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 100;
	// Documented times in nanoseconds.
	localparam int CONV_TIME_NS = 1000;
	localparam int MIN_START_NS = 500;
	localparam int VALID_LOW_NS = 100;
	// Cycle counts: least times round up, never below one cycle.
	localparam int CONV_CYC_RAW = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
	localparam int MIN_CYC_RAW = (MIN_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_CYC = (MIN_CYC_RAW < 1) ? 1 : MIN_CYC_RAW;
	localparam int VLOW_CYC_RAW = (VALID_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VLOW_CYC = (VLOW_CYC_RAW < 1) ? 1 : VLOW_CYC_RAW;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OFFSET = 8'h04;
	localparam logic [7:0] REG_RANGE = 8'h08;
	localparam logic [7:0] REG_CONV = 8'h0C;
	localparam logic [7:0] REG_MINSTART = 8'h10;
	localparam logic [7:0] REG_VLOW = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_RESULT = 8'h1C;
	// Control field positions.
	localparam int CTRL_SIGNED_BIT = 0;
	// Reset values and the unit counter step.
	localparam logic [31:0] RANGE_RST = 32'h0000_0100;
	localparam logic [15:0] ONE16 = 16'h0001;
	// AHB transfer type code for NONSEQ.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// [src/act_buf2.sv]
// Two-entry valid/ready buffer for converted samples.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/10ps
module act_buf2 #(
	parameter int W = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// Two storage words with a read pointer and fill count.
	logic [W-1:0] mem_q [2];
	logic rd_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage and pointer update; the write slot follows the read pointer.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else begin
			if (push) begin
				mem_q[rd_q ^ cnt_q[0]] <= in_data;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // act_buf2

// [testbench/act_src_model.sv]
// Behavioural front end: drives the conversion clock pin and the sample word.
// Assumes start() is called right after a rising hclk edge.
`timescale 1ns/10ps
module act_src_model #(
	parameter int SW = 32
) (
	// Bench clock.
	input wire logic hclk,
	// Converter pins.
	output logic conv_clk,
	output logic [SW-1:0] sample_in
);
	int hold_cnt = 0; // Cycles left before the sample stops being meaningful.
	initial begin
		conv_clk = 1'b0;
		sample_in = 32'h0000_0000;
	end
	// Once capture is over the word turns over, so a late read cannot pass by luck.
	always @(posedge hclk) begin
		if (hold_cnt == 1) begin
			sample_in <= ~sample_in;
		end
		if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end
	end
	// One rise of the pin, high for one cycle; the next rise may come gap cycles later.
	task automatic start(input logic [SW-1:0] v, input int gap);
		conv_clk <= 1'b1;
		sample_in <= v;
		hold_cnt <= 5;
		@(posedge hclk);
		conv_clk <= 1'b0;
		repeat (gap - 1) @(posedge hclk);
	endtask
endmodule // act_src_model

// [testbench/tb.sv]
// Self-checking bench for the conversion timing block.
// Assumes the front-end model above and default register values after reset.
`timescale 1ns/10ps
module tb;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, res_strm_ready;
	logic [31:0] haddr, hwdata, hrdata, sample_in, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic conv_clk, result_valid_q, res_strm_valid_q;
	logic [11:0] result_q, c;
	logic vprev = 1'b1; // Valid level at the previous falling edge.
	int miscompares = 0, compares = 0, cyc = 0, lowcnt = 0, lowlen = 0, l0, l1;
	logic [11:0] codes[$]; // Result codes seen at each valid drop.
	int falls[$]; // Cycle of each valid drop.
	assign hready = hreadyout;
	act_adc_timing #(.N(12), .SW(32)) act_adc_timing_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .conv_clk(conv_clk), .sample_in(sample_in), .result_q(result_q),
		.result_valid_q(result_valid_q), .res_strm_valid_q(res_strm_valid_q),
		.res_strm_ready(res_strm_ready));
	act_src_model #(.SW(32)) act_src_model_i (.hclk(hclk), .conv_clk(conv_clk),
		.sample_in(sample_in));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, cycle count and a monitor that samples settled outputs at the falling edge.
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) cyc <= cyc + 1;
	always @(negedge hclk) begin
		if (vprev === 1'b1 && result_valid_q === 1'b0) begin
			codes.push_back(result_q);
			falls.push_back(cyc);
		end
		if (result_valid_q === 1'b0) begin
			lowcnt++;
		end else if (lowcnt > 0) begin
			lowlen = lowcnt;
			lowcnt = 0;
		end
		vprev = result_valid_q;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Comparison, bus and conversion helpers.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	// Single AHB-Lite word; read data lands in rd at the end of the data phase.
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= act_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Expected code: offset removed, scaled over the range, clamped, MSB flipped if signed.
	function automatic logic [11:0] code(int s, int off, int rng, bit sg);
		int v;
		v = (s - off) * 4096 / rng + 2048;
		if (v < 0) v = 0;
		if (v > 4095) v = 4095;
		code = v[11:0];
		if (sg) code[11] = ~code[11];
	endfunction
	// One start, then wait a bounded time for its result.
	task automatic conv1(input int s, output int lat);
		int t;
		codes.delete();
		falls.delete();
		@(posedge hclk);
		t = cyc;
		act_src_model_i.start(s, 6);
		repeat (40) if (codes.size() == 0) @(posedge hclk);
		chk(codes.size(), 1, "result count");
		c = codes[0];
		lat = falls[0] - t;
		repeat (6) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic s_regs;
		ahb(act_pkg::REG_RANGE, 1'b0, 32'h0);
		chk(rd, act_pkg::RANGE_RST, "range reset");
		ahb(act_pkg::REG_CONV, 1'b0, 32'h0);
		chk(rd, act_pkg::CONV_CYC, "latency reset");
		ahb(act_pkg::REG_MINSTART, 1'b0, 32'h0);
		chk(rd, act_pkg::MIN_CYC, "interval reset");
		ahb(act_pkg::REG_VLOW, 1'b0, 32'h0);
		chk(rd, act_pkg::VLOW_CYC, "valid low reset");
		ahb(8'h40, 1'b0, 32'h0); // Unmapped place: must simply complete.
		chk(hresp, 1'b0, "okay response");
	endtask
	// Both codings over in-range, negative and saturating samples, then an offset.
	task automatic s_codes;
		int sv[5] = '{5, -10, 1000, -1000, 8};
		for (int sg = 0; sg < 2; sg++) begin
			ahb(act_pkg::REG_CTRL, 1'b1, 32'(sg));
			for (int i = 0; i < 5; i++) begin
				ahb(act_pkg::REG_OFFSET, 1'b1, (i == 4) ? 32'h0000_0008 : 32'h0000_0000);
				conv1(sv[i], l0);
				chk(c, code(sv[i], (i == 4) ? 8 : 0, 256, sg[0]), "code");
				ahb(act_pkg::REG_RESULT, 1'b0, 32'h0);
				chk(rd[11:0], c, "result register");
			end
		end
		chk(l0 >= act_pkg::CONV_CYC && l0 <= act_pkg::CONV_CYC + 5, 1, "latency");
		ahb(act_pkg::REG_CTRL, 1'b1, 32'h0000_0000);
		ahb(act_pkg::REG_OFFSET, 1'b1, 32'h0000_0000);
	endtask
	// Latency tracks the register exactly; valid stays low for the set time.
	task automatic s_timing;
		conv1(5, l0);
		chk(lowlen, act_pkg::VLOW_CYC, "valid low");
		ahb(act_pkg::REG_VLOW, 1'b1, 32'h0000_0003);
		ahb(act_pkg::REG_CONV, 1'b1, 32'h0000_0014);
		conv1(5, l1);
		chk(lowlen, 3, "valid low set");
		chk(l1 - l0, 10, "latency step");
		ahb(act_pkg::REG_CONV, 1'b1, 32'(act_pkg::CONV_CYC));
		ahb(act_pkg::REG_VLOW, 1'b1, 32'(act_pkg::VLOW_CYC));
	endtask
	// Overlapped starts with the receiver stalled, plus one start that comes too soon.
	task automatic s_overlap;
		ahb(act_pkg::REG_STATUS, 1'b0, 32'h0);
		res_strm_ready <= 1'b0;
		codes.delete();
		falls.delete();
		@(posedge hclk);
		act_src_model_i.start(16, 6);
		act_src_model_i.start(-16, 2);
		act_src_model_i.start(-16, 6);
		repeat (30) @(posedge hclk);
		chk(codes.size(), 2, "overlap count");
		chk(codes[0], code(16, 0, 256, 1'b0), "first");
		chk(codes[1], code(-16, 0, 256, 1'b0), "second");
		chk(falls[1] - falls[0], 6, "spacing");
		ahb(act_pkg::REG_STATUS, 1'b0, 32'h0);
		chk(rd[1], 1'b1, "drop flag");
		ahb(act_pkg::REG_STATUS, 1'b0, 32'h0);
		chk(rd[1], 1'b0, "drop flag clear");
		chk(res_strm_valid_q, 1'b1, "stream held");
		res_strm_ready <= 1'b1;
		repeat (5) @(posedge hclk);
		chk(res_strm_valid_q, 1'b0, "stream drained");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog.
	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		res_strm_ready = 1'b1;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		s_regs();
		s_codes();
		s_timing();
		s_overlap();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		tally_and_finish();
	end
endmodule // tb
